// File: include/port_cfg_pkg.sv
// package: offsets, field layouts and reset values of the per-port vendor configuration bank
package port_cfg_pkg;

  // ****************************************************************
  // register offsets (byte addresses in configuration space)
  // ****************************************************************
  localparam logic [7:0] OFS_LINK_WORD_THREE = 8'h80;
  localparam logic [7:0] OFS_LINK_WORD_FOUR  = 8'h84;
  localparam logic [7:0] OFS_LINK_WORD_FIVE  = 8'h88;
  localparam logic [7:0] OFS_TL_CONTROL      = 8'h8C;
  localparam logic [7:0] OFS_PHY_LANE_DELTA  = 8'h90;
  localparam logic [7:0] OFS_PHY_MARGIN_RXEQ = 8'h94;
  localparam logic [7:0] OFS_STRAP_MODE      = 8'h98;
  localparam logic [7:0] OFS_SUBSYS_CAP      = 8'hB0;
  localparam logic [7:0] OFS_SUBSYS_IDENT    = 8'hB4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_LINK_WORD_THREE = 32'h000F_0000;
  localparam logic [31:0] RST_LINK_WORD_FOUR  = 32'h0000_0000;
  localparam logic [29:0] RST_LINK_PARAM_UP   = 30'h3308_3333; // low 30 bits of 7308_3333
  localparam logic [29:0] RST_LINK_PARAM_DN   = 30'h3308_3333;
  localparam logic        RST_RATE_CHG_UP     = 1'h1;
  localparam logic        RST_RATE_CHG_DN     = 1'h0;
  localparam logic        RST_FIRST_RATE_ONLY = 1'h0;
  // tl control: bit4 resets to one, byte six at 23:16 resets to 79
  localparam logic [31:0] RST_TL_CONTROL      = 32'h0079_0010;
  localparam logic [31:0] TL_WRITE_MASK       = 32'h0000_0060;
  localparam logic [31:0] TL_RSVD_MASK        = 32'h4000_E800;
  localparam logic [6:0]  RST_LANE_MODE       = 7'h00;
  localparam logic [16:0] RST_PHY_DELTA       = 17'h0_0001;
  localparam logic [15:0] RST_TX_MARGIN       = 16'h116B;
  localparam logic [7:0]  RST_RX_EQUALISE_UP  = 8'h86;
  localparam logic [3:0]  RST_REFCLK_ENABLES  = 4'hF;
  localparam logic [7:0]  SUBSYS_CAP_ID       = 8'h0D;
  localparam logic [7:0]  SUBSYS_NEXT_PTR     = 8'hC0;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TL_BIT_ORDER_OFF   = 6;
  localparam int TL_POS_ATTEMPTS    = 8;
  localparam int TL_BIT_PORT_OFF    = 10;
  localparam int TL_POS_BYTE_SIX    = 16;
  localparam int MODE_BIT_CLOCK_BUFFER_POWERDOWN_STRAP = 20;
  localparam int MODE_POS_REFCLK    = 16;

  // operating straps, packed msb first as they sit in bits 15:0
  typedef struct packed {
    logic [6:0] zero;
    logic       scan_mode;
    logic [2:0] package_select_strap;
    logic       phy_test_strap;
    logic       debug_mode;
    logic       fast_mode;
    logic       quiescent_current_test;
    logic       serial_rom_skip;
  } strap_word_t;

  // configuration-space access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cfg_req_t;

  // side-band load from the smbus master or eeprom loader
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } load_req_t;

endpackage

// File: rtl/port_cfg_bank.sv
// design: per-port vendor configuration register bank with side-band load
// Contract
// - defaults may be overridden after reset by smbus or eeprom load
// - link parameter 29:0 of word five resets per upstream or downstream
// - rate change control bit 30 resets one upstream, zero downstream
// - bit 31 of word five limits to first rate when one, resets zero
// - tl control bit 6 set by software disables relaxed ordering rule
// - rate change attempt count from tl control bits 9:8, reset zero
// - tl control bit 10 disables port; read-only to software, loadable
// - byte six presented in tl control 23:16, loadable reset value
// - phy lane mode 6:0 resets zero, phy delta 31:15 resets one
// - rx equalise byte 23:16 upstream only, downstream reads zero
// - operating straps reported in operation mode bits 15:0
// - bit 20 resets to clock buffer power-down strap, one disables clocks
// - four reference clock enables in bits 19:16, reset all ones
// - capability header bits 7:0 return fixed subsystem identifier
// - capability header bits 15:8 point to pci express capability
// - subsystem vendor 15:0 and device 31:16 ident, reset zero, loadable
`timescale 1ns/1ps
`default_nettype none

module port_cfg_bank
  import port_cfg_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   upstream_i,
  input  wire port_cfg_pkg::strap_word_t straps_i,
  input  wire logic                   clock_buffer_powerdown_strap_i,
  input  wire port_cfg_pkg::cfg_req_t  cfg_req_i,
  input  wire port_cfg_pkg::load_req_t load_req_i,
  output logic [31:0]                 cfg_rdata_o,
  output logic                        cfg_rvalid_o,
  output logic                        order_rule_off_o,
  output logic [1:0]                  rate_change_attempts_o,
  output logic                        port_disable_o,
  output logic                        first_rate_only_o,
  output logic                        rate_change_control_o,
  output logic [3:0]                  reference_clock_outputs_o
);
  import port_cfg_pkg::*;

  // ****************************************************************
  // strap synchronisers: three stages, change taken when 2 and 3 agree
  // ****************************************************************
  logic [16:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
  logic        up_s1_q, up_s2_q, up_s3_q, up_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_s1_q <= 17'h0_0000;
      strap_s2_q <= 17'h0_0000;
      strap_s3_q <= 17'h0_0000;
      up_s1_q    <= 1'h0;
      up_s2_q    <= 1'h0;
      up_s3_q    <= 1'h0;
    end else if (clk_en_i) begin
      strap_s1_q <= {clock_buffer_powerdown_strap_i, straps_i};
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
      up_s1_q    <= upstream_i;
      up_s2_q    <= up_s1_q;
      up_s3_q    <= up_s2_q;
    end
  end

  // filtered levels; these never see reset, but follow the zeroed stages to zero while reset is held
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      for (int i = 0; i < 17; i++) begin
        if (strap_s2_q[i] == strap_s3_q[i]) strap_q[i] <= strap_s3_q[i];
      end
      if (up_s2_q == up_s3_q) up_q <= up_s3_q;
    end
  end

  // ****************************************************************
  // defaults are applied on the fifth cycle after reset releases
  // ****************************************************************
  // the port role and straps are only known through the synchronisers,
  // so reset marks the bank stale and the defaults land a few cycles later
  logic [2:0] init_cnt_q;
  logic       init_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      init_cnt_q <= 3'h0;
      init_q     <= 1'h1;
    end else if (clk_en_i && init_q) begin
      init_cnt_q <= init_cnt_q + 3'h1;
      if (init_cnt_q == 3'h4) init_q <= 1'h0;
    end
  end

  wire logic init_load = init_q && (init_cnt_q == 3'h4);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [31:0] word_three_q, word_four_q, word_five_q, tl_q;
  logic [6:0]  lane_mode_q;
  logic [16:0] phy_delta_q;
  logic [15:0] tx_margin_q;
  logic [7:0]  rx_equalise_q;
  logic [4:0]  clkbuf_q;
  logic [31:0] subsys_ident_q;

  function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    return wr && (a == ofs);
  endfunction

  wire logic ld  = load_req_i.wr && !init_q;
  wire logic sw  = cfg_req_i.wr && !init_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      word_three_q   <= RST_LINK_WORD_THREE;
      word_four_q    <= RST_LINK_WORD_FOUR;
      word_five_q    <= {RST_FIRST_RATE_ONLY, RST_RATE_CHG_DN, RST_LINK_PARAM_DN};
      tl_q           <= RST_TL_CONTROL;
      lane_mode_q    <= RST_LANE_MODE;
      phy_delta_q    <= RST_PHY_DELTA;
      tx_margin_q    <= RST_TX_MARGIN;
      rx_equalise_q  <= 8'h00;
      clkbuf_q       <= {1'h0, RST_REFCLK_ENABLES};
      subsys_ident_q <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (init_load) begin
        word_five_q <= up_q ? {RST_FIRST_RATE_ONLY, RST_RATE_CHG_UP, RST_LINK_PARAM_UP}
                            : {RST_FIRST_RATE_ONLY, RST_RATE_CHG_DN, RST_LINK_PARAM_DN};
        rx_equalise_q <= up_q ? RST_RX_EQUALISE_UP : 8'h00;
        clkbuf_q      <= {strap_q[16], RST_REFCLK_ENABLES};
      end
      // side-band load overrides any default but downstream rx equalise; reserved bits are written too
      // software write comes first so that a load on the same edge wins
      if (hit(sw, cfg_req_i.addr, OFS_LINK_WORD_THREE)) word_three_q <= cfg_req_i.wdata;
      if (hit(ld, load_req_i.addr, OFS_LINK_WORD_THREE)) word_three_q <= load_req_i.wdata;
      if (hit(ld, load_req_i.addr, OFS_LINK_WORD_FOUR))  word_four_q  <= load_req_i.wdata;
      if (hit(ld, load_req_i.addr, OFS_LINK_WORD_FIVE))  word_five_q  <= load_req_i.wdata;
      if (hit(ld, load_req_i.addr, OFS_TL_CONTROL)) begin
        tl_q <= load_req_i.wdata;
      end else if (hit(sw, cfg_req_i.addr, OFS_TL_CONTROL)) begin
        // only bits 5 and 6 are software-writable
        tl_q <= (tl_q & ~TL_WRITE_MASK) | (cfg_req_i.wdata & TL_WRITE_MASK);
      end
      if (hit(ld, load_req_i.addr, OFS_PHY_LANE_DELTA)) begin
        lane_mode_q <= load_req_i.wdata[6:0];
        phy_delta_q <= load_req_i.wdata[31:15];
      end
      if (hit(ld, load_req_i.addr, OFS_PHY_MARGIN_RXEQ)) begin
        tx_margin_q <= load_req_i.wdata[15:0];
        if (up_q) rx_equalise_q <= load_req_i.wdata[23:16];
      end
      if (hit(ld, load_req_i.addr, OFS_STRAP_MODE)) clkbuf_q <= load_req_i.wdata[20:16];
      if (hit(ld, load_req_i.addr, OFS_SUBSYS_IDENT)) subsys_ident_q <= load_req_i.wdata;
    end
  end

  // ****************************************************************
  // read decode
  // ****************************************************************
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (cfg_req_i.addr)
      OFS_LINK_WORD_THREE: rd_d = word_three_q;
      OFS_LINK_WORD_FOUR:  rd_d = word_four_q;
      OFS_LINK_WORD_FIVE:  rd_d = word_five_q;
      OFS_TL_CONTROL:      rd_d = tl_q & ~TL_RSVD_MASK;
      OFS_PHY_LANE_DELTA:  rd_d = {phy_delta_q, 8'h00, lane_mode_q};
      OFS_PHY_MARGIN_RXEQ: rd_d = {8'h00, rx_equalise_q, tx_margin_q};
      OFS_STRAP_MODE:      rd_d = {11'h000, clkbuf_q, 7'h00, strap_q[8:0]};
      OFS_SUBSYS_CAP:      rd_d = {16'h0000, SUBSYS_NEXT_PTR, SUBSYS_CAP_ID};
      OFS_SUBSYS_IDENT:    rd_d = subsys_ident_q;
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cfg_rdata_o  <= 32'h0000_0000;
      cfg_rvalid_o <= 1'h0;
    end else if (clk_en_i) begin
      cfg_rvalid_o <= cfg_req_i.rd;
      if (cfg_req_i.rd) cfg_rdata_o <= rd_d;
    end
  end

  // ****************************************************************
  // fields that steer the switch core
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      order_rule_off_o          <= 1'h0;
      rate_change_attempts_o    <= 2'h0;
      port_disable_o            <= 1'h0;
      first_rate_only_o         <= 1'h0;
      rate_change_control_o     <= 1'h0;
      reference_clock_outputs_o <= 4'h0;
    end else if (clk_en_i) begin
      order_rule_off_o       <= tl_q[TL_BIT_ORDER_OFF];
      rate_change_attempts_o <= tl_q[TL_POS_ATTEMPTS +: 2];
      port_disable_o         <= tl_q[TL_BIT_PORT_OFF];
      first_rate_only_o      <= word_five_q[31];
      rate_change_control_o  <= word_five_q[30];
      // global power-down overrides the per-output enables; clocks stay off
      // until the strap is known, so a strapped-off part never pulses them
      reference_clock_outputs_o <= (clkbuf_q[4] || init_q) ? 4'h0 : clkbuf_q[3:0];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_sw_tl_ro;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && sw && !load_req_i.wr && cfg_req_i.addr == OFS_TL_CONTROL)
      |=> (tl_q & ~TL_WRITE_MASK) == ($past(tl_q) & ~TL_WRITE_MASK);
  endproperty
  a_sw_tl_ro: assert property (p_sw_tl_ro) else $error("tl read-only bits changed by software");

  property p_order_out;
    @(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i |=> order_rule_off_o == $past(tl_q[6]);
  endproperty
  a_order_out: assert property (p_order_out) else $error("ordering control not followed");

  property p_word_five_up;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && init_load && up_q) |=> word_five_q[30] && !word_five_q[31];
  endproperty
  a_word_five_up: assert property (p_word_five_up) else $error("upstream word five default wrong");

  property p_word_five_dn;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && init_load && !up_q && !ld) |=> word_five_q == {2'b00, RST_LINK_PARAM_DN};
  endproperty
  a_word_five_dn: assert property (p_word_five_dn) else $error("downstream word five default wrong");

  property p_rxeq_dn;
    @(posedge ref_clk_i) disable iff (rst_i)
    (!init_q && !up_q) |-> rx_equalise_q == 8'h00;
  endproperty
  a_rxeq_dn: assert property (p_rxeq_dn) else $error("downstream rx equalise not zero");

  property p_clk_pd;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && clkbuf_q[4]) |=> reference_clock_outputs_o == 4'h0;
  endproperty
  a_clk_pd: assert property (p_clk_pd) else $error("clocks not gated by power-down");

  property p_cap_read;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && cfg_req_i.rd && cfg_req_i.addr == OFS_SUBSYS_CAP)
      |=> cfg_rvalid_o && cfg_rdata_o == 32'h0000_C00D;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability header wrong");

  property p_tl_rsvd;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && cfg_req_i.rd && cfg_req_i.addr == OFS_TL_CONTROL)
      |=> (cfg_rdata_o & TL_RSVD_MASK) == 32'h0000_0000;
  endproperty
  a_tl_rsvd: assert property (p_tl_rsvd) else $error("reserved tl bits read non-zero");

  property p_attempts;
    @(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i |=> rate_change_attempts_o == $past(tl_q[9:8]);
  endproperty
  a_attempts: assert property (p_attempts) else $error("attempt count not followed");

  property p_port_off;
    @(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i |=> port_disable_o == $past(tl_q[10]);
  endproperty
  a_port_off: assert property (p_port_off) else $error("port disable not followed");

  property p_first_rate;
    @(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i |=> first_rate_only_o == $past(word_five_q[31]);
  endproperty
  a_first_rate: assert property (p_first_rate) else $error("first rate limit not followed");

  property p_rate_chg;
    @(posedge ref_clk_i) disable iff (rst_i)
    clk_en_i |=> rate_change_control_o == $past(word_five_q[30]);
  endproperty
  a_rate_chg: assert property (p_rate_chg) else $error("rate change control not followed");

  property p_load_wins;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && ld && load_req_i.addr == OFS_LINK_WORD_THREE)
      |=> word_three_q == $past(load_req_i.wdata);
  endproperty
  a_load_wins: assert property (p_load_wins) else $error("load to word three not taken");

  property p_sw_tl_rw;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && sw && !load_req_i.wr && cfg_req_i.addr == OFS_TL_CONTROL)
      |=> (tl_q & TL_WRITE_MASK) == ($past(cfg_req_i.wdata) & TL_WRITE_MASK);
  endproperty
  a_sw_tl_rw: assert property (p_sw_tl_rw) else $error("tl writable bits not taken");

  property p_ident_ro;
    @(posedge ref_clk_i) disable iff (rst_i)
    (clk_en_i && !(ld && load_req_i.addr == OFS_SUBSYS_IDENT))
      |=> subsys_ident_q == $past(subsys_ident_q);
  endproperty
  a_ident_ro: assert property (p_ident_ro) else $error("ident changed without load");

endmodule

`default_nettype wire

// File: test/port_cfg_bank_tb.sv
// testbench: reset values, software writes, side-band loads and steering outputs of the bank
`timescale 1ns/1ps
`default_nettype none

module port_cfg_bank_tb;
  import port_cfg_pkg::*;

  logic        ref_clk_i;
  logic        rst_i;
  logic        clk_en_i;
  logic        upstream_i;
  strap_word_t straps_i;
  logic        clock_buffer_powerdown_strap_i;
  cfg_req_t    cfg_req_i;
  load_req_t   load_req_i;
  logic [31:0] cfg_rdata_o;
  logic        cfg_rvalid_o;
  logic        order_rule_off_o;
  logic [1:0]  rate_change_attempts_o;
  logic        port_disable_o;
  logic        first_rate_only_o;
  logic        rate_change_control_o;
  logic [3:0]  reference_clock_outputs_o;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  integer      seed;
  int          miscompares;
  int          num_checks;

  port_cfg_bank u_dut (
    .ref_clk_i                      (ref_clk_i),
    .rst_i                          (rst_i),
    .clk_en_i                       (clk_en_i),
    .upstream_i                     (upstream_i),
    .straps_i                       (straps_i),
    .clock_buffer_powerdown_strap_i (clock_buffer_powerdown_strap_i),
    .cfg_req_i                      (cfg_req_i),
    .load_req_i                     (load_req_i),
    .cfg_rdata_o                    (cfg_rdata_o),
    .cfg_rvalid_o                   (cfg_rvalid_o),
    .order_rule_off_o               (order_rule_off_o),
    .rate_change_attempts_o         (rate_change_attempts_o),
    .port_disable_o                 (port_disable_o),
    .first_rate_only_o              (first_rate_only_o),
    .rate_change_control_o          (rate_change_control_o),
    .reference_clock_outputs_o      (reference_clock_outputs_o)
  );

  // ****************************************************************
  // clock, verdict and watchdog
  // ****************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole sequence is under two hundred cycles; this leaves ample margin
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    miscompares++;
    wrap_up();
  end

  // ****************************************************************
  // compares and read-data monitor
  // ****************************************************************
  task automatic chk_rdata(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected read data: expected %h seen %h", exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // sampled mid-cycle, where the registered read pulse and its data have settled
  always @(negedge ref_clk_i) begin
    if (cfg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_pin("unrequested read", 32'h0, 32'h1);
      end else begin
        chk_rdata(exp_q.pop_front(), cfg_rdata_o);
      end
    end
  end

  // ****************************************************************
  // drivers: each request is launched at one edge, idle lowers them
  // ****************************************************************
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    cfg_req_i  <= {1'b1, 1'b0, a, 32'h0};
    load_req_i <= '0;
    exp_q.push_back(e);
  endtask

  // the other channel is dropped so a request left standing is not taken twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    cfg_req_i  <= {1'b0, 1'b1, a, d};
    load_req_i <= '0;
  endtask

  task automatic ld(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    cfg_req_i  <= '0;
    load_req_i <= {1'b1, a, d};
  endtask

  // the trailing delay lets the design's edge updates land before pins are compared
  task automatic idle(input int n);
    @(posedge ref_clk_i);
    cfg_req_i  <= '0;
    load_req_i <= '0;
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // role and straps settle well before release; first access after the init window
  task automatic do_reset(input logic up, input logic pd);
    @(posedge ref_clk_i);
    rst_i                          <= 1'b1;
    upstream_i                     <= up;
    clock_buffer_powerdown_strap_i <= pd;
    straps_i                       <= strap_word_t'($random(seed));
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 32'h4522a004;
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    upstream_i = 1'b1;
    straps_i = '0;
    clock_buffer_powerdown_strap_i = 1'b0;
    cfg_req_i = '0;
    load_req_i = '0;
    do_reset(1'b1, 1'b0);
    rd(8'h80, 32'h000F_0000);
    rd(8'h84, 32'h0000_0000);
    rd(8'h88, 32'h7308_3333);
    rd(8'h8C, 32'h0079_0010);
    rd(8'h90, 32'h0000_8000);
    rd(8'h94, 32'h0086_116B);
    rd(8'h98, {11'h0, 1'b0, 4'hF, 7'h0, straps_i[8:0]});
    rd(8'hB0, 32'h0000_C00D);
    rd(8'hB4, 32'h0000_0000);
    rd(8'h9C, 32'h0000_0000);
    idle(3);
    chk_pin("first rate only", 32'h0, {31'h0, first_rate_only_o});
    chk_pin("rate change control", 32'h1, {31'h0, rate_change_control_o});
    chk_pin("refclk enables", 32'hF, {28'h0, reference_clock_outputs_o});
    chk_pin("port disable", 32'h0, {31'h0, port_disable_o});
    // software may touch only bits 5 and 6 of tl control; read-only words stay put
    wr(8'h8C, 32'hFFFF_FFFF);
    wr(8'h88, 32'hFFFF_FFFF);
    wr(8'hB4, 32'hFFFF_FFFF);
    idle(2);
    rd(8'h8C, 32'h0079_0070);
    rd(8'h88, 32'h7308_3333);
    rd(8'hB4, 32'h0000_0000);
    idle(1);
    chk_pin("order rule off", 32'h1, {31'h0, order_rule_off_o});
    chk_pin("port disable", 32'h0, {31'h0, port_disable_o});
    rnd = $random(seed);
    wr(8'h80, rnd);
    idle(1);
    rd(8'h80, rnd);
    // loads override the tl, word five, ident, phy and margin defaults; all attempt codes and both disable values
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      rnd[9:8] = i[1:0];
      rnd[10] = i[0];
      rnd[6] = i[1];
      ld(8'h8C, rnd);
      ld(8'h88, rnd);
      ld(8'hB4, rnd);
      ld(8'h90, rnd);
      ld(8'h94, rnd);
      idle(2);
      rd(8'h8C, rnd & ~32'h4000_E800);
      rd(8'h88, rnd);
      rd(8'hB4, rnd);
      rd(8'h90, rnd & 32'hFFFF_807F);
      rd(8'h94, {8'h0, rnd[23:16], rnd[15:0]});
      idle(1);
      chk_pin("port disable", {31'h0, rnd[10]}, {31'h0, port_disable_o});
      chk_pin("attempts", {30'h0, rnd[9:8]}, {30'h0, rate_change_attempts_o});
      chk_pin("order rule off", {31'h0, rnd[6]}, {31'h0, order_rule_off_o});
      chk_pin("first rate only", {31'h0, rnd[31]}, {31'h0, first_rate_only_o});
      chk_pin("rate change control", {31'h0, rnd[30]}, {31'h0, rate_change_control_o});
    end
    // a load and a software write landing on the same edge: the load wins
    @(posedge ref_clk_i);
    cfg_req_i  <= {1'b0, 1'b1, 8'h80, 32'h1234_5678};
    load_req_i <= {1'b1, 8'h80, 32'h8765_4321};
    idle(1);
    rd(8'h80, 32'h8765_4321);
    ld(8'h98, 32'h0015_0000);
    idle(2);
    chk_pin("refclk enables", 32'h0, {28'h0, reference_clock_outputs_o});
    ld(8'h98, 32'h0005_0000);
    idle(2);
    chk_pin("refclk enables", 32'h5, {28'h0, reference_clock_outputs_o});
    // downstream role with the clock buffer strap set
    do_reset(1'b0, 1'b1);
    rd(8'h88, 32'h3308_3333);
    rd(8'h94, 32'h0000_116B);
    rd(8'h98, {11'h0, 1'b1, 4'hF, 7'h0, straps_i[8:0]});
    ld(8'h94, 32'hFFFF_FFFF);
    idle(2);
    rd(8'h94, 32'h0000_FFFF);
    idle(3);
    chk_pin("refclk enables", 32'h0, {28'h0, reference_clock_outputs_o});
    chk_pin("rate change control", 32'h0, {31'h0, rate_change_control_o});
    chk_pin("pending reads", 32'h0, exp_q.size());
    wrap_up();
  end

endmodule

`default_nettype wire
